// File: core/offset_corrector_freeze_bypass.sv
// Paged register control of the two channel offset correctors
`timescale 1ns/100ps
// Notes on behaviour
// - A bypassed corrector passes the sample data through with no offset removal.
// - A frozen corrector stops estimating but keeps subtracting its last estimate.
// - Writing C2h to corrector_control freezes the corrector of the selected channel.
// - Writing 46h to corrector_control bypasses the corrector of the selected channel.
// - An active corrector keeps estimating and removes the per-phase offset tones.
module offset_corrector_freeze_bypass (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [ocb_pkg::AW-1:0] reg_addr_i,
    input wire logic [ocb_pkg::DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    output logic [ocb_pkg::DW-1:0] reg_rdata_o,
    input wire logic samp_valid_i,
    input wire logic signed [ocb_pkg::SW-1:0] samp_i [ocb_pkg::NCH],
    output logic samp_valid_o,
    output logic signed [ocb_pkg::OW-1:0] samp_o [ocb_pkg::NCH],
    output logic [ocb_pkg::NCH-1:0] idle_o
);
    import ocb_pkg::*;

    logic [DW-1:0] page_select_byte0;
    logic [DW-1:0] page_select_byte1;
    logic [DW-1:0] page_select_channel_byte;
    logic [DW-1:0] page_select_block_byte;
    logic [DW-1:0] corrector_control [NCH];
    logic page_ok;
    logic sel_ch;
    logic ctrl_wr;
    logic [DW-1:0] next_rdata;
    logic [DW-1:0] status;
    logic [NCH-1:0] valid_out;

    ocb_chan_if chan [NCH] ();

    // -------------------------------------------------------------
    // Page decode
    // -------------------------------------------------------------
    // Corrector page match for channel A or channel B
    assign page_ok = page_select_byte0 == PAGE_ZERO && page_select_byte1 == PAGE_ZERO
        && page_select_block_byte == PAGE_BLOCK_CORR
        && (page_select_channel_byte == PAGE_CHAN_A || page_select_channel_byte == PAGE_CHAN_B);
    assign sel_ch = (page_select_channel_byte == PAGE_CHAN_B);
    assign ctrl_wr = reg_wr_i && reg_addr_i == ADDR_CTRL && page_ok;

    // -------------------------------------------------------------
    // Page select registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            page_select_byte0 <= REG_RESET;
            page_select_byte1 <= REG_RESET;
            page_select_channel_byte <= REG_RESET;
            page_select_block_byte <= REG_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_PAGE0: page_select_byte0 <= reg_wdata_i;
                ADDR_PAGE1: page_select_byte1 <= reg_wdata_i;
                ADDR_PAGE_CHAN: page_select_channel_byte <= reg_wdata_i;
                ADDR_PAGE_BLOCK: page_select_block_byte <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // Per-channel control and corrector
    // -------------------------------------------------------------
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                corrector_control[g] <= REG_RESET;
            end else if (ctrl_wr && sel_ch == 1'(g)) begin
                corrector_control[g] <= reg_wdata_i;
            end
        end

        assign chan[g].freeze = (corrector_control[g] == CTRL_FREEZE);
        assign chan[g].bypass = (corrector_control[g] == CTRL_BYPASS);
        assign chan[g].in_valid = samp_valid_i;
        assign chan[g].in_data = samp_i[g];
        assign samp_o[g] = chan[g].out_data;
        assign valid_out[g] = chan[g].out_valid;
        assign idle_o[g] = chan[g].idle;

        offset_corrector u_corr (
            .clk_sys_i(clk_sys_i),
            .resetn_i(resetn_i),
            .ch(chan[g])
        );

        a_freeze_write: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            (ctrl_wr && sel_ch == 1'(g) && reg_wdata_i == CTRL_FREEZE)
            |-> ##2 (chan[g].mode == MODE_FROZEN))
            else $error("freeze write did not freeze channel");
        a_bypass_write: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            (ctrl_wr && sel_ch == 1'(g) && reg_wdata_i == CTRL_BYPASS)
            |-> ##2 (chan[g].mode == MODE_BYPASS))
            else $error("bypass write did not bypass channel");
        a_other_unchanged: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            (reg_wr_i && !(ctrl_wr && sel_ch == 1'(g)))
            |=> (corrector_control[g] == $past(corrector_control[g])))
            else $error("unselected channel control changed");
        a_idle_drop: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            (samp_valid_i && samp_i[g] >= $signed(IDLE_THRESH)) |=> !idle_o[g])
            else $error("idle flag set on a live input");
        a_code_active: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            (ctrl_wr && sel_ch == 1'(g) && reg_wdata_i != CTRL_FREEZE
                && reg_wdata_i != CTRL_BYPASS)
            |-> ##2 (chan[g].mode == MODE_ACTIVE))
            else $error("other control code did not restore estimation");
        a_valid_per_chan: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            samp_valid_i |=> valid_out[g])
            else $error("channel output valid missing");
    end

    assign samp_valid_o = valid_out[0];

    // -------------------------------------------------------------
    // Read back
    // -------------------------------------------------------------
    always_comb begin
        status = '0;
        status[ST_IDLE] = idle_o[sel_ch];
        status[ST_FROZEN] = (chan[0].mode == MODE_FROZEN && !sel_ch)
            || (chan[1].mode == MODE_FROZEN && sel_ch);
        status[ST_BYPASS] = (chan[0].mode == MODE_BYPASS && !sel_ch)
            || (chan[1].mode == MODE_BYPASS && sel_ch);
        status[ST_PAGE_OK] = page_ok;
        case (reg_addr_i)
            ADDR_PAGE0: next_rdata = page_select_byte0;
            ADDR_PAGE1: next_rdata = page_select_byte1;
            ADDR_PAGE_CHAN: next_rdata = page_select_channel_byte;
            ADDR_PAGE_BLOCK: next_rdata = page_select_block_byte;
            ADDR_CTRL: next_rdata = page_ok ? corrector_control[sel_ch] : REG_RESET;
            ADDR_STATUS: next_rdata = status;
            default: next_rdata = REG_RESET;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= REG_RESET;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    a_page_write_only: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == ADDR_CTRL && !page_ok)
        |=> (corrector_control[0] == $past(corrector_control[0])
            && corrector_control[1] == $past(corrector_control[1])))
        else $error("control write without page took effect");
    a_bypass_path: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (chan[0].mode == MODE_BYPASS && samp_valid_i) |=> (samp_o[0] == OW'($past(samp_i[0]))))
        else $error("bypassed channel A altered data");

    a_bypass_path_b: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (chan[1].mode == MODE_BYPASS && samp_valid_i)
        |=> (samp_o[1] == OW'($past(samp_i[1]))))
        else $error("bypassed channel B altered data");

    // -------------------------------------------------------------
    // Register and routing checks
    // -------------------------------------------------------------
    a_page_byte0_store: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == ADDR_PAGE0)
        |=> (page_select_byte0 == $past(reg_wdata_i)))
        else $error("page byte 0 write not stored");

    a_page_byte1_store: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == ADDR_PAGE1)
        |=> (page_select_byte1 == $past(reg_wdata_i)))
        else $error("page byte 1 write not stored");

    a_page_chan_store: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == ADDR_PAGE_CHAN)
        |=> (page_select_channel_byte == $past(reg_wdata_i)))
        else $error("page channel write not stored");

    a_page_block_store: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == ADDR_PAGE_BLOCK)
        |=> (page_select_block_byte == $past(reg_wdata_i)))
        else $error("page block write not stored");

    a_route_chan_a: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (ctrl_wr && page_select_channel_byte == PAGE_CHAN_A)
        |=> (corrector_control[0] == $past(reg_wdata_i)))
        else $error("control write missed channel A");

    a_route_chan_b: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (ctrl_wr && page_select_channel_byte == PAGE_CHAN_B)
        |=> (corrector_control[1] == $past(reg_wdata_i)))
        else $error("control write missed channel B");

    a_ctrl_read_refused: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_addr_i == ADDR_CTRL && !page_ok) |=> (reg_rdata_o == REG_RESET))
        else $error("control read without page returned data");
endmodule : offset_corrector_freeze_bypass

// File: core/ocb_pkg.sv
// Constants and types shared by the offset corrector control block
package ocb_pkg;
    // -------------------------------------------------------------
    // Widths, counts and shift amounts
    // -------------------------------------------------------------
    localparam int NCH = 2;
    localparam int SW = 14;
    localparam int OW = 15;
    localparam int AW = 16;
    localparam int DW = 8;
    localparam int NPH = 8;
    localparam int PHW = 3;
    localparam int FRAC = 6;
    localparam int LEAK = 4;
    localparam int EW = SW + FRAC + 1;
    localparam int ICW = 5;
    // -------------------------------------------------------------
    // Register addresses
    // -------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_PAGE0 = 16'h4001;
    localparam logic [AW-1:0] ADDR_PAGE1 = 16'h4002;
    localparam logic [AW-1:0] ADDR_PAGE_CHAN = 16'h4003;
    localparam logic [AW-1:0] ADDR_PAGE_BLOCK = 16'h4004;
    localparam logic [AW-1:0] ADDR_CTRL = 16'h6068;
    localparam logic [AW-1:0] ADDR_STATUS = 16'h6069;
    // -------------------------------------------------------------
    // Register values
    // -------------------------------------------------------------
    localparam logic [DW-1:0] PAGE_ZERO = 8'h00;
    localparam logic [DW-1:0] PAGE_BLOCK_CORR = 8'h61;
    localparam logic [DW-1:0] PAGE_CHAN_A = 8'h00;
    localparam logic [DW-1:0] PAGE_CHAN_B = 8'h01;
    localparam logic [DW-1:0] CTRL_FREEZE = 8'hC2;
    localparam logic [DW-1:0] CTRL_BYPASS = 8'h46;
    localparam logic [DW-1:0] REG_RESET = 8'h00;
    localparam int ST_IDLE = 0;
    localparam int ST_FROZEN = 1;
    localparam int ST_BYPASS = 2;
    localparam int ST_PAGE_OK = 3;
    // -------------------------------------------------------------
    // Idle detection and corrector modes
    // -------------------------------------------------------------
    localparam logic [SW-1:0] IDLE_THRESH = 14'h0010;
    localparam logic [ICW-1:0] IDLE_LEN = 5'h10;
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b001,
        MODE_FROZEN = 3'b010,
        MODE_BYPASS = 3'b100
    } mode_t;
endpackage : ocb_pkg

// File: core/ocb_chan_if.sv
// Interface between the register block and one channel corrector
`timescale 1ns/100ps
interface ocb_chan_if;
    import ocb_pkg::*;
    logic freeze;
    logic bypass;
    logic in_valid;
    logic signed [SW-1:0] in_data;
    logic out_valid;
    logic signed [OW-1:0] out_data;
    logic idle;
    mode_t mode;
    modport ctrl (
        output freeze, bypass, in_valid, in_data,
        input out_valid, out_data, idle, mode
    );
    modport core (
        input freeze, bypass, in_valid, in_data,
        output out_valid, out_data, idle, mode
    );
endinterface : ocb_chan_if

// File: core/offset_corrector.sv
// One channel offset mismatch estimator and corrector
`timescale 1ns/100ps
module offset_corrector (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    ocb_chan_if.core ch
);
    import ocb_pkg::*;

    logic [PHW-1:0] phase;
    logic signed [EW-1:0] est [NPH];
    logic signed [OW-1:0] est_cur;
    logic [ICW-1:0] idle_cnt;
    mode_t next_mode;

    // -------------------------------------------------------------
    // Mode
    // -------------------------------------------------------------
    always_comb begin
        if (ch.bypass) begin
            next_mode = MODE_BYPASS;
        end else if (ch.freeze) begin
            next_mode = MODE_FROZEN;
        end else begin
            next_mode = MODE_ACTIVE;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ch.mode <= MODE_ACTIVE;
        end else begin
            case (ch.mode)
                MODE_ACTIVE: ch.mode <= next_mode;
                MODE_FROZEN: ch.mode <= next_mode;
                MODE_BYPASS: ch.mode <= next_mode;
                default: ch.mode <= MODE_ACTIVE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // Interleave phase
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= '0;
        end else if (ch.in_valid) begin
            phase <= phase + 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Per-phase estimates
    // -------------------------------------------------------------
    for (genvar p = 0; p < NPH; p++) begin : g_est
        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                est[p] <= '0;
            end else if (ch.in_valid && phase == PHW'(p) && ch.mode == MODE_ACTIVE) begin
                est[p] <= est[p] + ((((EW'(ch.in_data)) <<< FRAC) - est[p]) >>> LEAK);
            end
        end
    end

    assign est_cur = OW'(est[phase] >>> FRAC);

    // -------------------------------------------------------------
    // Output
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ch.out_valid <= 1'b0;
            ch.out_data <= '0;
        end else begin
            ch.out_valid <= ch.in_valid;
            if (ch.mode == MODE_BYPASS) begin
                ch.out_data <= OW'(ch.in_data);
            end else begin
                ch.out_data <= OW'(ch.in_data) - est_cur;
            end
        end
    end

    // -------------------------------------------------------------
    // Idle input detection
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idle_cnt <= '0;
            ch.idle <= 1'b0;
        end else if (ch.in_valid) begin
            if (ch.in_data < $signed(IDLE_THRESH) && ch.in_data > -$signed(IDLE_THRESH)) begin
                if (idle_cnt != IDLE_LEN) begin
                    idle_cnt <= idle_cnt + 1'b1;
                end
                ch.idle <= (idle_cnt == IDLE_LEN);
            end else begin
                idle_cnt <= '0;
                ch.idle <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    a_bypass_raw_out: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (ch.mode == MODE_BYPASS && ch.in_valid) |=> (ch.out_data == OW'($past(ch.in_data))))
        else $error("bypass output differs from input");
    a_frozen_est_hold: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (ch.mode == MODE_FROZEN) |=> (est[$past(phase)] == $past(est[phase])))
        else $error("estimate changed while frozen");
    a_active_tracks: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (ch.mode == MODE_ACTIVE && ch.in_valid
            && ((EW'(ch.in_data) <<< FRAC) - est[phase]) >>> LEAK != '0)
        |=> (est[$past(phase)] != $past(est[phase])))
        else $error("active estimate did not update");
endmodule : offset_corrector

// File: testbench/ocb_host_model.sv
// Host model: register writer and sample source for the corrector block
`timescale 1ns/100ps
module ocb_host_model (
    input wire logic clk_sys_i,
    input wire logic [ocb_pkg::DW-1:0] reg_rdata_i,
    output logic [ocb_pkg::AW-1:0] reg_addr_o,
    output logic [ocb_pkg::DW-1:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic samp_valid_o,
    output logic signed [ocb_pkg::SW-1:0] samp_o [ocb_pkg::NCH]
);
    import ocb_pkg::*;
    localparam int EST_CYC = 4000;
    localparam int IDLE_CYC = 32;
    int level = 0;
    int phase = 0;
    int offs [NPH] = '{3, -2, 5, -4, 1, 0, -3, 2};
    initial begin
        reg_addr_o = '0;
        reg_wdata_o = '0;
        reg_wr_o = 1'b0;
        samp_valid_o = 1'b1;
    end
    // -------------------------------------------------------------
    // Sample source
    // -------------------------------------------------------------
    // Source level plus per-phase offsets on channel A, minus them on channel B; level 0 gives offsets only
    always @(negedge clk_sys_i) begin
        samp_o[0] <= SW'(level + offs[phase]);
        samp_o[1] <= SW'(level - offs[phase]);
        phase <= (phase + 1) % NPH;
    end
    // -------------------------------------------------------------
    // Register access
    // -------------------------------------------------------------
    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(negedge clk_sys_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask : wr_reg
    task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(negedge clk_sys_i);
        reg_addr_o = a;
        @(posedge clk_sys_i);
        #10;
        d = reg_rdata_i;
    endtask : rd_reg
    task automatic sel_page();
        wr_reg(ADDR_PAGE0, PAGE_ZERO);
        wr_reg(ADDR_PAGE1, PAGE_ZERO);
        wr_reg(ADDR_PAGE_CHAN, PAGE_CHAN_A);
        wr_reg(ADDR_PAGE_BLOCK, PAGE_BLOCK_CORR);
    endtask : sel_page
    task automatic settle();
        repeat (EST_CYC + IDLE_CYC) @(negedge clk_sys_i);
    endtask : settle
endmodule : ocb_host_model

// File: testbench/tb_offset_corrector_freeze_bypass.sv
// Testbench for the offset corrector freeze and bypass control
`timescale 1ns/100ps
module tb_offset_corrector_freeze_bypass;
    import ocb_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata;
    logic reg_wr;
    logic [DW-1:0] reg_rdata;
    logic samp_valid_in;
    logic signed [SW-1:0] samp_in [NCH];
    logic samp_valid_out;
    logic signed [OW-1:0] samp_out [NCH];
    logic [NCH-1:0] idle;
    int fail_count = 0;
    int checks = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    offset_corrector_freeze_bypass i_offset_corrector_freeze_bypass (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rdata_o(reg_rdata),
        .samp_valid_i(samp_valid_in), .samp_i(samp_in), .samp_valid_o(samp_valid_out),
        .samp_o(samp_out), .idle_o(idle)
    );
    ocb_host_model i_ocb_host_model (
        .clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .samp_valid_o(samp_valid_in),
        .samp_o(samp_in)
    );
    // -------------------------------------------------------------
    // Compare, sample capture and result tasks
    // -------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_near(input logic signed [15:0] got, input logic signed [15:0] exp);
        checks++;
        if ($isunknown(got) || got < exp || got > exp + 16'sh0001) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_near
    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        logic [DW-1:0] d;
        i_ocb_host_model.rd_reg(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rd_chk
    task automatic grab(output logic signed [15:0] a, output logic signed [15:0] b,
                        output logic signed [15:0] ia, output logic signed [15:0] ib);
        @(posedge clk_sys_i);
        #10;
        a = samp_out[0];
        b = samp_out[1];
        ia = samp_in[0];
        ib = samp_in[1];
    endtask : grab
    task automatic wrap_up();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    // -------------------------------------------------------------
    // Watchdog
    // -------------------------------------------------------------
    initial begin
        #2000000;
        fail_count++;
        wrap_up();
    end
    // -------------------------------------------------------------
    // Test sequence
    // -------------------------------------------------------------
    initial begin
        logic signed [15:0] a;
        logic signed [15:0] b;
        logic signed [15:0] ia;
        logic signed [15:0] ib;
        repeat (5) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        rd_chk(ADDR_PAGE_BLOCK, REG_RESET);
        rd_chk(ADDR_CTRL, REG_RESET);
        chk({15'h0000, samp_valid_out}, 16'h0001);
        i_ocb_host_model.wr_reg(ADDR_CTRL, CTRL_FREEZE);
        i_ocb_host_model.settle();
        chk({14'h0000, idle}, 16'h0003);
        for (int i = 0; i < NPH; i++) begin
            grab(a, b, ia, ib);
            chk_near(a, 16'sh0000);
            chk_near(b, 16'sh0000);
        end
        i_ocb_host_model.sel_page();
        rd_chk(ADDR_PAGE_BLOCK, PAGE_BLOCK_CORR);
        rd_chk(ADDR_STATUS, 8'h09);
        i_ocb_host_model.wr_reg(ADDR_CTRL, CTRL_FREEZE);
        i_ocb_host_model.wr_reg(ADDR_PAGE_CHAN, PAGE_CHAN_B);
        rd_chk(ADDR_STATUS, 8'h09);
        i_ocb_host_model.wr_reg(ADDR_CTRL, CTRL_FREEZE);
        rd_chk(ADDR_STATUS, 8'h0B);
        rd_chk(ADDR_CTRL, CTRL_FREEZE);
        i_ocb_host_model.level = 1000;
        repeat (300) @(negedge clk_sys_i);
        chk({14'h0000, idle}, 16'h0000);
        for (int i = 0; i < NPH; i++) begin
            grab(a, b, ia, ib);
            chk_near(a, 16'sd1000);
            chk_near(b, 16'sd1000);
        end
        i_ocb_host_model.sel_page();
        i_ocb_host_model.wr_reg(ADDR_CTRL, CTRL_BYPASS);
        i_ocb_host_model.wr_reg(ADDR_PAGE_CHAN, PAGE_CHAN_B);
        rd_chk(ADDR_STATUS, 8'h0A);
        for (int i = 0; i < NPH; i++) begin
            grab(a, b, ia, ib);
            chk(a, ia);
            chk_near(b, 16'sd1000);
        end
        i_ocb_host_model.wr_reg(ADDR_CTRL, CTRL_BYPASS);
        rd_chk(ADDR_STATUS, 8'h0C);
        repeat (4) @(negedge clk_sys_i);
        for (int i = 0; i < NPH; i++) begin
            grab(a, b, ia, ib);
            chk(a, ia);
            chk(b, ib);
        end
        i_ocb_host_model.wr_reg(ADDR_CTRL, REG_RESET);
        rd_chk(ADDR_STATUS, 8'h08);
        wrap_up();
    end
endmodule : tb_offset_corrector_freeze_bypass
